// File: logic/sfpb_pkg.sv
// Purpose: shared constants and types of the page buffer command link
// Assumes: 200 MHz system clock on both ends
// Notes:   times are given in ns and turned into cycle counts here
package sfpb_pkg;
  localparam int CLK_PERIOD_NS = 5;

  // opcodes
  localparam logic [7:0] OP_SEC_READ = 8'h77;
  localparam logic [7:0] OP_XFER_B1  = 8'h53;
  localparam logic [7:0] OP_XFER_B2  = 8'h55;
  localparam logic [7:0] OP_CMP_B1   = 8'h60;
  localparam logic [7:0] OP_CMP_B2   = 8'h61;
  localparam logic [7:0] OP_REWR_B1  = 8'h58;
  localparam logic [7:0] OP_REWR_B2  = 8'h59;
  localparam logic [7:0] OP_STATUS   = 8'hd7;

  // geometry
  localparam int SEC_BYTES      = 128;
  localparam int PAGE_COUNT     = 2048;
  localparam int PAGE_BITS      = 11;
  localparam int PAGE_BYTES_264 = 264;
  localparam int PAGE_BYTES_256 = 256;
  localparam int MEM_AW         = 20;
  localparam logic [2:0] HDR_BYTES  = 3'h4;
  localparam logic [2:0] RX_CNT_MAX = 3'h5;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // address byte layout (page field lsb in the 24-bit address)
  localparam int ADDR264_PAGE_LSB = 9;
  localparam int ADDR256_PAGE_LSB = 8;

  // status byte fields
  localparam int ST_RDY_BIT   = 7;
  localparam int ST_COMP_BIT  = 6;
  localparam int ST_DENS_LSB  = 2;
  localparam int ST_PROT_BIT  = 1;
  localparam int ST_PSIZE_BIT = 0;
  localparam int ST2_EPE_BIT  = 5;
  localparam logic [3:0] DENSITY_CODE = 4'h7;

  // internal operation times
  localparam int PAGE_COPY_TIME_NS          = 2000;
  localparam int PAGE_COMPARE_TIME_NS       = 2000;
  localparam int PAGE_ERASE_PROGRAM_TIME_NS = 20000;
  localparam int TIMER_W = 12;
  localparam logic [TIMER_W-1:0] PAGE_COPY_CYCLES =
    TIMER_W'(PAGE_COPY_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] PAGE_COMPARE_CYCLES =
    TIMER_W'(PAGE_COMPARE_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] PAGE_ERASE_PROGRAM_CYCLES =
    TIMER_W'(PAGE_ERASE_PROGRAM_TIME_NS / CLK_PERIOD_NS);

  // host serial clock: half period in system cycles
  localparam logic [4:0] SCK_HALF_CYCLES = 5'h10;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_COPY = 3'b001,
    ST_PROG = 3'b011,
    ST_WAIT = 3'b010,
    ST_CMP  = 3'b110
  } sfpb_op_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SEND = 3'b001,
    H_READ = 3'b011,
    H_PUSH = 3'b010,
    H_END  = 3'b110
  } sfpb_host_state_t;
endpackage

// File: logic/sfpb_spi_if.sv
// Purpose: serial link between host end and device end
// Assumes: one device per link; so is read directly, and only the monitor looks at so_oe
// Notes:   no clocking block; plain wires only
interface sfpb_spi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;

  modport dev_end (input cs_n, input sck, input si,
                   output so, output so_oe);
  modport host_end (output cs_n, output sck, output si,
                    input so, input so_oe);
endinterface

// File: logic/sfpb_dev_end.sv
// Purpose: device end, decodes commands and runs page buffer operations
// Assumes: host keeps serial clock at 16 system cycles per half or slower
// Notes:   mode 0 link, sampled on rising and driven on falling clock

module sfpb_dev_end
  import sfpb_pkg::*;
#(
  parameter logic [7:0] SEC_SEED = 8'h5a  // arbitrary per-device seed
) (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   reset_n,
  // serial link
  sfpb_spi_if.dev_end link,
  // configuration strap, caught after reset release
  input  wire logic   page_size_256,
  // state
  output logic        busy
);
  logic                   cs_q, sck_q, si_q, cs_d, sck_d;
  logic                   strap_done, mode256, out_active;
  logic [7:0]             main_mem [0:PAGE_COUNT*PAGE_BYTES_264-1];
  logic [PAGE_COUNT-1:0]  page_written;
  logic [7:0]             buf_mem [0:1][0:PAGE_BYTES_264-1];
  logic [7:0]             rmw_dat [0:PAGE_BYTES_264-1];
  logic [PAGE_BYTES_264-1:0] rmw_vld;
  logic [6:0]             rx_sh;
  logic [2:0]             rx_bit, rx_cnt, obit;
  logic [7:0]             opcode, out_sh, oidx, st1, st2, out_byte;
  logic [23:0]            addr;
  logic [8:0]             dat_ptr;
  sfpb_op_state_t         state;
  logic                   sel_buf, op_rewrite, op_cmp, cmp_acc, comp;
  logic [PAGE_BITS-1:0]   op_page;
  logic [8:0]             op_len, idx;
  logic [TIMER_W-1:0]     timer;

  sfpb_pin_sync #(.INIT(1'b1)) u_cs (.clk(clk), .reset_n(reset_n),
                                     .d(link.cs_n), .q(cs_q));
  sfpb_pin_sync #(.INIT(1'b0)) u_sck (.clk(clk), .reset_n(reset_n),
                                      .d(link.sck), .q(sck_q));
  sfpb_pin_sync #(.INIT(1'b0)) u_si (.clk(clk), .reset_n(reset_n),
                                     .d(link.si), .q(si_q));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_d  <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_d  <= cs_q;
      sck_d <= sck_q;
    end
  end

  wire sck_rise = sck_q & ~sck_d & ~cs_q;
  wire sck_fall = ~sck_q & sck_d & ~cs_q;
  wire cs_rise  = cs_q & ~cs_d;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done <= 1'b0;
      mode256    <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      mode256    <= page_size_256;
    end
  end

  // command decode
  wire [7:0]  rx_byte   = {rx_sh, si_q};
  wire        byte_done = sck_rise && (rx_bit == 3'h7);
  wire [23:0] next_addr = {addr[15:0], rx_byte};
  wire        is_rewrite = (opcode == OP_REWR_B1) ||
                           (opcode == OP_REWR_B2);
  wire        is_cmp  = (opcode == OP_CMP_B1) ||
                        (opcode == OP_CMP_B2);
  wire        is_xfer = (opcode == OP_XFER_B1) ||
                        (opcode == OP_XFER_B2);
  wire        buf_two = (opcode == OP_XFER_B2) || (opcode == OP_CMP_B2) ||
                        (opcode == OP_REWR_B2);
  wire [8:0]  page_len = mode256 ? 9'(PAGE_BYTES_256)
                                 : 9'(PAGE_BYTES_264);
  wire [PAGE_BITS-1:0] cmd_page = mode256 ?
    addr[ADDR256_PAGE_LSB +: PAGE_BITS] :
    addr[ADDR264_PAGE_LSB +: PAGE_BITS];
  wire [8:0]  first_ptr = mode256 ? {1'b0, next_addr[7:0]}
                                  : next_addr[8:0];
  wire [8:0]  ptr_inc   = (dat_ptr == page_len - 9'h1) ? 9'h0
                                                       : dat_ptr + 9'h1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sh      <= 7'h0;
      rx_bit     <= 3'h0;
      rx_cnt     <= 3'h0;
      opcode     <= 8'h0;
      addr       <= 24'h0;
      dat_ptr    <= 9'h0;
      out_active <= 1'b0;
    end else if (cs_q) begin
      rx_bit     <= 3'h0;
      rx_cnt     <= 3'h0;
      out_active <= 1'b0;
    end else if (sck_rise) begin
      rx_sh  <= rx_byte[6:0];
      rx_bit <= rx_bit + 3'h1;
      if (rx_bit == 3'h7) begin
        if (rx_cnt != RX_CNT_MAX) begin
          rx_cnt <= rx_cnt + 3'h1;
        end
        if (rx_cnt == 3'h0) begin
          opcode     <= rx_byte;
          out_active <= (rx_byte == OP_STATUS);
        end else if (rx_cnt < HDR_BYTES) begin
          addr <= next_addr;
          if (rx_cnt == HDR_BYTES - 3'h1) begin
            dat_ptr    <= first_ptr;
            out_active <= (opcode == OP_SEC_READ);
          end
        end else if (is_rewrite) begin
          dat_ptr <= ptr_inc;
        end
      end
    end
  end

  // read-modify-write data, captured only while idle
  wire rmw_take = byte_done && !busy && is_rewrite &&
                  (rx_cnt >= HDR_BYTES);

  always_ff @(posedge clk) begin
    if (rmw_take) begin
      rmw_dat[dat_ptr] <= rx_byte;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rmw_vld <= '0;
    end else if (byte_done && !busy && (rx_cnt == 3'h0)) begin
      rmw_vld <= '0;
    end else if (rmw_take) begin
      rmw_vld[dat_ptr] <= 1'b1;
    end
  end

  // output stream
  function automatic logic [7:0] sec_byte(input logic [6:0] i);
    sec_byte = {i, 1'b0} ^ SEC_SEED;
  endfunction

  always_comb begin
    st1 = 8'h0;
    st1[ST_RDY_BIT]  = ~busy;
    st1[ST_COMP_BIT] = comp;
    st1[ST_DENS_LSB +: 4] = DENSITY_CODE;
    st1[ST_PROT_BIT]  = 1'b0;
    st1[ST_PSIZE_BIT] = mode256;
    st2 = 8'h0;
    st2[ST_RDY_BIT]  = ~busy;
    st2[ST2_EPE_BIT] = 1'b0;
    if (opcode == OP_STATUS) begin
      out_byte = oidx[0] ? st2 : st1;
    end else if (oidx < 8'(SEC_BYTES)) begin
      out_byte = sec_byte(oidx[6:0]);
    end else begin
      out_byte = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link.so    <= 1'b0;
      link.so_oe <= 1'b0;
      out_sh     <= 8'h0;
      obit       <= 3'h0;
      oidx       <= 8'h0;
    end else if (cs_q) begin
      link.so    <= 1'b0;
      link.so_oe <= 1'b0;
      obit       <= 3'h0;
      oidx       <= 8'h0;
    end else if (sck_fall && out_active) begin
      link.so_oe <= 1'b1;
      if (obit == 3'h0) begin
        link.so <= out_byte[7];
        out_sh  <= {out_byte[6:0], 1'b0};
      end else begin
        link.so <= out_sh[7];
        out_sh  <= {out_sh[6:0], 1'b0};
      end
      obit <= obit + 3'h1;
      if (obit == 3'h7) begin
        oidx <= oidx + 8'h1;
      end
    end
  end

  // internal operations
  wire start = cs_rise && !busy && (rx_cnt >= HDR_BYTES) &&
               (rx_bit == 3'h0) && (is_xfer || is_cmp || is_rewrite);
  wire [MEM_AW-1:0] mem_addr = MEM_AW'(op_page) *
                               MEM_AW'(PAGE_BYTES_264) + MEM_AW'(idx);
  wire [7:0] page_byte = page_written[op_page] ? main_mem[mem_addr]
                                               : ERASED_BYTE;
  wire       last = (idx == op_len - 9'h1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= ST_IDLE;
      busy       <= 1'b0;
      sel_buf    <= 1'b0;
      op_rewrite <= 1'b0;
      op_cmp     <= 1'b0;
      op_page    <= '0;
      op_len     <= 9'h0;
      idx        <= 9'h0;
      timer      <= '0;
      cmp_acc    <= 1'b0;
      comp       <= 1'b0;
    end else begin
      if (timer != '0) begin
        timer <= timer - TIMER_W'(1);
      end
      case (state)
        ST_IDLE: begin
          if (start) begin
            busy       <= 1'b1;
            sel_buf    <= buf_two;
            op_rewrite <= is_rewrite;
            op_cmp     <= is_cmp;
            op_page    <= cmd_page;
            op_len     <= page_len;
            idx        <= 9'h0;
            cmp_acc    <= 1'b0;
            if (is_cmp) begin
              state <= ST_CMP;
              timer <= PAGE_COMPARE_CYCLES;
            end else begin
              state <= ST_COPY;
              timer <= is_rewrite ? PAGE_ERASE_PROGRAM_CYCLES
                                  : PAGE_COPY_CYCLES;
            end
          end
        end
        ST_COPY: begin
          idx <= last ? 9'h0 : idx + 9'h1;
          if (last) begin
            state <= op_rewrite ? ST_PROG : ST_WAIT;
          end
        end
        ST_PROG: begin
          idx <= idx + 9'h1;
          if (last) begin
            state <= ST_WAIT;
          end
        end
        ST_CMP: begin
          cmp_acc <= cmp_acc |
                     (page_byte != buf_mem[sel_buf][idx]);
          idx <= idx + 9'h1;
          if (last) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (timer == '0) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
            if (op_cmp) begin
              comp <= cmp_acc;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (state == ST_COPY) begin
      buf_mem[sel_buf][idx] <= rmw_vld[idx] ? rmw_dat[idx]
                                            : page_byte;
    end
    if (state == ST_PROG) begin
      main_mem[mem_addr] <= buf_mem[sel_buf][idx];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_written <= '0;
    end else if (state == ST_PROG) begin
      page_written[op_page] <= 1'b1;
    end
  end
endmodule

// File: logic/sfpb_host_end.sv
// Purpose: host end, shifts commands out and collects answer bytes
// Assumes: device file is compiled with this one; pin sync lives here
// Notes:   received bytes pass a small fifo; a full fifo stalls the clock

module sfpb_pin_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic d,
  output logic      q
);
  logic s1, s2, s3;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q  <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule

module sfpb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // shift fifo: head always sits in entry 0, straight from flops
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [DEPTH-1:0] vld;
  wire              pop  = vld[0] && out_ready;
  wire              push = in_valid && !vld[DEPTH-1];
  // entries left after a pop, and the first free one among them
  wire [DEPTH-1:0]  kept = pop ? (vld >> 1) : vld;
  wire [DEPTH-1:0]  slot = ~kept & {kept[DEPTH-2:0], 1'b1};

  assign in_ready  = !vld[DEPTH-1];
  assign out_valid = vld[0];
  assign out_data  = mem[0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vld <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      vld <= push ? (kept | slot) : kept;
      if (pop) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          mem[i] <= mem[i+1];
        end
      end
      for (int i = 0; i < DEPTH; i++) begin
        if (push && slot[i]) begin
          mem[i] <= in_data;
        end
      end
    end
  end
endmodule

module sfpb_host_end
  import sfpb_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // serial link
  sfpb_spi_if.host_end     link,
  // command request
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic        cmd_addr_en,
  input  wire logic [10:0] cmd_page,
  input  wire logic        cmd_mode256,
  input  wire logic [7:0]  cmd_rx_len,
  // received bytes
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [7:0]       rx_data
);
  sfpb_host_state_t state;
  logic [4:0]       div;
  logic             tick, so_q, f_ready;
  logic [31:0]      tx_sh;
  logic [5:0]       tx_last, bits;
  logic [7:0]       rx_sh, rx_left;
  logic [2:0]       rbit;

  sfpb_pin_sync #(.INIT(1'b0)) u_so (.clk(clk), .reset_n(reset_n),
                                     .d(link.so), .q(so_q));

  sfpb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .reset_n(reset_n),
    .in_valid(state == H_PUSH), .in_ready(f_ready), .in_data(rx_sh),
    .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div  <= 5'h0;
      tick <= 1'b0;
    end else if (state == H_IDLE && cmd_valid && cmd_ready) begin
      // restart at a take so select leads the first clock edge
      tick <= 1'b0;
      div  <= 5'h0;
    end else begin
      tick <= (div == SCK_HALF_CYCLES - 5'h1);
      div  <= (div == SCK_HALF_CYCLES - 5'h1) ? 5'h0 : div + 5'h1;
    end
  end

  wire [23:0] addr24 = cmd_mode256 ? {5'h0, cmd_page, 8'h0}
                                   : {4'h0, cmd_page, 9'h0};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= H_IDLE;
      cmd_ready <= 1'b0;
      link.cs_n <= 1'b1;
      link.sck  <= 1'b0;
      link.si   <= 1'b0;
      tx_sh     <= 32'h0;
      tx_last   <= 6'h0;
      bits      <= 6'h0;
      rx_sh     <= 8'h0;
      rx_left   <= 8'h0;
      rbit      <= 3'h0;
    end else begin
      case (state)
        H_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            link.cs_n <= 1'b0;
            link.sck  <= 1'b0;
            link.si   <= cmd_opcode[7];
            tx_sh     <= {cmd_opcode, addr24};
            tx_last   <= cmd_addr_en ? 6'h1f : 6'h07;
            rx_left   <= cmd_rx_len;
            bits      <= 6'h0;
            rbit      <= 3'h0;
            state     <= H_SEND;
          end else if (tick) begin
            cmd_ready <= 1'b1;
          end
        end
        H_SEND: begin
          if (tick) begin
            link.sck <= ~link.sck;
            if (link.sck) begin
              bits  <= bits + 6'h1;
              tx_sh <= {tx_sh[30:0], 1'b0};
              link.si <= tx_sh[30];
              if (bits == tx_last) begin
                state <= (rx_left == 8'h0) ? H_END : H_READ;
              end
            end
          end
        end
        H_READ: begin
          if (tick) begin
            link.sck <= ~link.sck;
            if (!link.sck) begin
              rx_sh <= {rx_sh[6:0], so_q};
              rbit  <= rbit + 3'h1;
              if (rbit == 3'h7) begin
                state <= H_PUSH;
              end
            end
          end
        end
        H_PUSH: begin
          if (f_ready) begin
            rx_left <= rx_left - 8'h1;
            state   <= (rx_left == 8'h1) ? H_END : H_READ;
          end
        end
        H_END: begin
          if (tick) begin
            if (link.sck) begin
              link.sck <= 1'b0;
            end else begin
              link.cs_n <= 1'b1;
              state     <= H_IDLE;
            end
          end
        end
        default: begin
          state     <= H_IDLE;
          link.cs_n <= 1'b1;
        end
      endcase
    end
  end
endmodule

// File: tb/sfpb_monitor.sv
// Purpose: link and busy checks beside the joining interface
// Assumes: host half period of 16 cycles, one clock domain
// Notes:   busy length counted in helper logic
module sfpb_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  // state
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [12:0] busy_len;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      busy_len <= 13'h0;
    else if (busy)
      busy_len <= busy_len + 13'h1;
    else
      busy_len <= 13'h0;
  end

  oe_off_a: assert property (cs_n [*6] |-> !so_oe)
    else $error("output enable left on while deselected");
  oe_rise_a: assert property ($rose(so_oe) |-> !cs_n && !sck)
    else $error("output enable rose outside a frame");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  cs_setup_a: assert property ($fell(cs_n) |=> !sck [*8])
    else $error("serial clock too soon after select");
  busy_start_a: assert property ($rose(busy) |-> cs_n && $past(cs_n, 2))
    else $error("busy rose inside a frame");
  busy_min_a: assert property ($rose(busy) |=> busy [*8])
    else $error("busy pulse too short");
  busy_len_a: assert property ($fell(busy) |->
    busy_len inside {[13'h18b:13'h195], [13'hf9b:13'hfa5]})
    else $error("busy length off");
  busy_cap_a: assert property (busy_len <= 13'hfaa)
    else $error("busy held too long");
  si_hold_a: assert property (!cs_n && sck && $past(sck) |->
    $stable(si))
    else $error("serial input moved while clock high");
  so_hold_a: assert property (so_oe && sck && $past(sck) |->
    $stable(so))
    else $error("serial output moved while clock high");
endmodule

// File: tb/test_serial_flash_page_buffer_commands.sv
// Purpose: drives both ends, checks id, status and page commands
// Assumes: strap and host layout flag set alike in each pass
// Notes:   pass 0 uses 264-byte pages, pass 1 uses 256-byte pages
module test_serial_flash_page_buffer_commands
  import sfpb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] SEED_ID = 8'ha7; // arbitrary id seed

  logic        clk, reset_n, mode, busy;
  logic        cmd_valid, cmd_ready, cmd_addr_en, cmd_mode256;
  logic        rx_valid, rx_ready;
  logic [7:0]  cmd_opcode, cmd_rx_len, rx_data;
  logic [10:0] cmd_page, pg, pq;
  logic [7:0]  got[$];
  int          num_errors, n_tests, seed;

  sfpb_spi_if link ();

  sfpb_dev_end #(.SEC_SEED(SEED_ID)) i_sfpb_dev_end (.clk(clk),
    .reset_n(reset_n), .link(link.dev_end), .page_size_256(mode),
    .busy(busy));
  sfpb_host_end i_sfpb_host_end (.clk(clk), .reset_n(reset_n),
    .link(link.host_end), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_opcode(cmd_opcode), .cmd_addr_en(cmd_addr_en),
    .cmd_page(cmd_page), .cmd_mode256(cmd_mode256),
    .cmd_rx_len(cmd_rx_len), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data));
  sfpb_monitor i_sfpb_monitor (.clk(clk), .reset_n(reset_n),
    .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so(link.so),
    .so_oe(link.so_oe), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic timeout;
    num_errors++;
    end_sim();
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // one command; stall keeps rx_ready low so the fifo fills
  task automatic do_cmd(input logic [7:0] op, input logic [10:0] p,
                        input logic [7:0] n, input int stall);
    got.delete();
    for (int k = 0; cmd_ready !== 1'b1; k++) begin
      if (k > 300) timeout();
      @(negedge clk);
    end
    cmd_valid = 1'b1;
    cmd_opcode = op;
    cmd_addr_en = (op != OP_STATUS);
    cmd_page = p;
    cmd_mode256 = mode;
    cmd_rx_len = n;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (int k = 0; got.size() < n || cmd_ready !== 1'b1; k++) begin
      if (k > 50000) timeout();
      if (stall > 0 && k == stall - 1)
        chk("rx_hold", 8'h1, {7'h0, rx_valid});
      rx_ready = (k >= stall);
      if (rx_valid === 1'b1 && rx_ready)
        got.push_back(rx_data);
      @(negedge clk);
    end
  endtask

  task automatic wait_idle;
    for (int k = 0; busy !== 1'b0; k++) begin
      if (k > 5000) timeout();
      @(negedge clk);
    end
  endtask

  task automatic st(input logic rdy, input logic comp);
    do_cmd(OP_STATUS, 11'h0, 8'h2, 0);
    chk("status1", {rdy, comp, 4'h7, 1'b0, mode}, got[0]);
    chk("status2", {rdy, 7'h0}, got[1]);
  endtask

  initial begin
    seed = 32'h126b4ef4;
    {reset_n, mode, cmd_valid, rx_ready, cmd_addr_en, cmd_mode256} = '0;
    cmd_opcode = 8'h0;
    cmd_page = 11'h0;
    cmd_rx_len = 8'h0;
    num_errors = 0;
    n_tests = 0;
    for (int m = 0; m < 2; m++) begin
      reset_n = 1'b0;
      mode = m[0];
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      repeat (5) @(negedge clk);
      pg = 11'($random(seed));
      pq = pg ^ 11'h400;
      do_cmd(OP_SEC_READ, 11'h0, 8'h80 >> (4 * m), 3000);
      foreach (got[i])
        chk("id", {i[6:0], 1'b0} ^ SEED_ID, got[i]);
      st(1'b1, 1'b0);
      do_cmd(m ? OP_REWR_B2 : OP_REWR_B1, 11'h7ff, 8'h0, 0);
      chk("busy", 8'h1, {7'h0, busy});
      st(1'b0, 1'b0);
      wait_idle();
      do_cmd(m ? OP_XFER_B2 : OP_XFER_B1, pg, 8'h0, 0);
      chk("busy", 8'h1, {7'h0, busy});
      wait_idle();
      do_cmd(m ? OP_CMP_B2 : OP_CMP_B1, pg, 8'h0, 0);
      chk("busy", 8'h1, {7'h0, busy});
      wait_idle();
      st(1'b1, 1'b0);
      do_cmd(m ? OP_REWR_B2 : OP_REWR_B1, pq, 8'h1, 0);
      wait_idle();
      do_cmd(m ? OP_CMP_B2 : OP_CMP_B1, pg, 8'h0, 0);
      wait_idle();
      st(1'b1, 1'b1);
    end
    end_sim();
  end
endmodule
